// [rtl/mcr_pkg.sv]
// Package: constants for the machine-check error code reporter
package mcr_pkg;
   // Bank count and code width
   localparam int unsigned NUM_BANKS = 4;
   localparam int unsigned CODE_W    = 16;

   // Simple global codes
   localparam logic [15:0] CODE_NONE          = 16'h0000;
   localparam logic [15:0] CODE_UNCLASSIFIED  = 16'h0001;
   localparam logic [15:0] CODE_UCODE_PARITY  = 16'h0002;
   localparam logic [15:0] CODE_EXTERNAL      = 16'h0003;
   localparam logic [15:0] CODE_REDUNDANCY    = 16'h0004;
   localparam logic [15:0] CODE_INT_TIMER     = 16'h0400;
   localparam logic [15:0] CODE_INT_UNCLASS   = 16'h0400;

   // Compound form marker bits and field positions
   localparam int unsigned FILTER_BIT   = 12;
   localparam int unsigned BUS_BIT      = 11;
   localparam int unsigned CACHE_BIT    = 8;
   localparam int unsigned TLB_BIT      = 4;
   localparam int unsigned PART_LSB     = 9;
   localparam int unsigned TIMEOUT_BIT  = 8;
   localparam int unsigned REQ_LSB      = 4;
   localparam int unsigned TT_LSB       = 2;
   localparam int unsigned LL_LSB       = 0;
   localparam logic [1:0]  GENERIC_MARK = 2'h3;

   // Event kinds
   localparam logic [3:0] EV_UNCLASSIFIED = 4'h0;
   localparam logic [3:0] EV_UCODE_PARITY = 4'h1;
   localparam logic [3:0] EV_EXTERNAL     = 4'h2;
   localparam logic [3:0] EV_REDUNDANCY   = 4'h3;
   localparam logic [3:0] EV_INT_TIMER    = 4'h4;
   localparam logic [3:0] EV_INT_UNCLASS  = 4'h5;
   localparam logic [3:0] EV_GENERIC_MEM  = 4'h6;
   localparam logic [3:0] EV_TLB          = 4'h7;
   localparam logic [3:0] EV_CACHE        = 4'h8;
   localparam logic [3:0] EV_BUS          = 4'h9;

   // Register byte offsets; bank status words follow at BANK_BASE + 4*bank
   localparam logic [7:0] OFS_CTRL      = 8'h00;
   localparam logic [7:0] OFS_IRQ_STAT  = 8'h04;
   localparam logic [7:0] OFS_IRQ_EN    = 8'h08;
   localparam logic [7:0] OFS_IRQ_CLR   = 8'h0c;
   localparam logic [7:0] OFS_BANK_BASE = 8'h10;
   localparam logic [7:0] OFS_BANK_CLR  = 8'h20;

   // Bank status word layout
   localparam int unsigned STAT_MODEL_LSB = 16;
   localparam int unsigned STAT_VALID_BIT = 31;

   // Control bits and reset values
   localparam int unsigned CTRL_MCE_BIT = 0;
   localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
   localparam logic [7:0]  IRQ_RESET    = 8'h00;
endpackage : mcr_pkg

// [rtl/mcr_reporter.sv]
// Machine-check error code reporter with bank status registers on Wishbone
//
// Summary of operation
// - On an error event a 16-bit code is written into one bank's code field.
// - Logging a code into a bank also sets that bank's valid flag.
// - A 15-bit model-specific code (err_model_code[14:0]) is stored beside the code in bits 30:16.
// - The code alone tells the error kind; the bank is chosen by the event.
// - A bank with no error reported holds code zero.
// - Unclassified errors report code one.
// - Microcode memory parity errors report code two.
// - A bus-init machine check from another processor reports code three.
// - Redundancy pair master/slave mismatch reports code four.
// - Internal unclassified sets bit 10 with nonzero 9:0; all-zero 9:0 means timer.
// - Bus-init raises machine check only if strap observation and enable bit are set.
// - Generic memory hierarchy: filter bit 12, bits 3:2 = 11, level in 1:0.
// - Translation buffer: bit 4 set, type 3:2, level 1:0, filter bit 12.
// - Cache hierarchy: bit 8, request 7:4, type 3:2, level 1:0, filter bit 12.
// - Bus error: bit 11, part 10:9, timeout 8, request 7:4, io 3:2, level 1:0, filter 12.
//
// Added by the designer: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module mcr_reporter (
   // Clock, reset and enable
   input  wire logic        sys_clk,
   input  wire logic        reset,
   input  wire logic        clk_en,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Error event input, same clock domain
   input  wire logic        err_valid,
   input  wire logic [3:0]  err_kind,
   input  wire logic [1:0]  err_bank,
   input  wire logic        err_filter,
   input  wire logic [1:0]  err_level,
   input  wire logic [1:0]  err_type,
   input  wire logic [3:0]  err_request,
   input  wire logic [1:0]  err_part,
   input  wire logic        err_timeout,
   input  wire logic [9:0]  err_detail,
   input  wire logic [15:0] err_model_code,
   // Bus-init pin and power-on strap, asynchronous
   input  wire logic        bus_init_signal,
   input  wire logic        bus_init_strap,
   // Machine check and interrupt outputs
   output logic             machine_check,
   output logic             irq
);
   localparam int unsigned NB = mcr_pkg::NUM_BANKS;

   logic [31:0]     bank_error_status_register [NB];
   logic [31:0]     ctrl;
   logic [7:0]      irq_stat;
   logic [7:0]      irq_en;
   logic [1:0]      bi_sync;
   logic [1:0]      strap_sync;
   logic            strap_seen;
   logic            strap_taken;
   logic [1:0]      strap_wait;
   logic            bi_prev;
   logic            bi_rise;
   logic            bi_event;
   logic            log_en;
   logic [15:0]     next_code;
   logic [1:0]      log_bank;
   logic            wb_req;
   logic            wr_req;
   logic [7:0]      bank_clr_mask;
   logic [7:0]      irq_set;

   // Builds the architectural code from event kind and sub-fields
   function automatic logic [15:0] encode(input logic [3:0] kind, input logic f, input logic [1:0] ll,
                                          input logic [1:0] tt, input logic [3:0] rr, input logic [1:0] pp,
                                          input logic t, input logic [9:0] det);
      logic [15:0] c;
      c = mcr_pkg::CODE_NONE;
      unique case (kind)
         mcr_pkg::EV_UCODE_PARITY: c = mcr_pkg::CODE_UCODE_PARITY;
         mcr_pkg::EV_EXTERNAL:     c = mcr_pkg::CODE_EXTERNAL;
         mcr_pkg::EV_REDUNDANCY:   c = mcr_pkg::CODE_REDUNDANCY;
         mcr_pkg::EV_INT_TIMER:    c = mcr_pkg::CODE_INT_TIMER;
         mcr_pkg::EV_INT_UNCLASS: begin
            // Zero detail would alias the timer code, so force bit 0
            c = mcr_pkg::CODE_INT_UNCLASS | {6'h00, det};
            if (det == 10'h000) begin
               c[0] = 1'b1;
            end
         end
         mcr_pkg::EV_GENERIC_MEM: begin
            c[mcr_pkg::FILTER_BIT] = f;
            c[mcr_pkg::TT_LSB +: 2] = mcr_pkg::GENERIC_MARK;
            c[mcr_pkg::LL_LSB +: 2] = ll;
         end
         mcr_pkg::EV_TLB: begin
            c[mcr_pkg::FILTER_BIT] = f;
            c[mcr_pkg::TLB_BIT] = 1'b1;
            c[mcr_pkg::TT_LSB +: 2] = tt;
            c[mcr_pkg::LL_LSB +: 2] = ll;
         end
         mcr_pkg::EV_CACHE: begin
            c[mcr_pkg::FILTER_BIT] = f;
            c[mcr_pkg::CACHE_BIT] = 1'b1;
            c[mcr_pkg::REQ_LSB +: 4] = rr;
            c[mcr_pkg::TT_LSB +: 2] = tt;
            c[mcr_pkg::LL_LSB +: 2] = ll;
         end
         mcr_pkg::EV_BUS: begin
            c[mcr_pkg::FILTER_BIT] = f;
            c[mcr_pkg::BUS_BIT] = 1'b1;
            c[mcr_pkg::PART_LSB +: 2] = pp;
            c[mcr_pkg::TIMEOUT_BIT] = t;
            c[mcr_pkg::REQ_LSB +: 4] = rr;
            c[mcr_pkg::TT_LSB +: 2] = tt;
            c[mcr_pkg::LL_LSB +: 2] = ll;
         end
         default: c = mcr_pkg::CODE_UNCLASSIFIED;
      endcase
      return c;
   endfunction : encode

   // Two-flop synchronisers for the asynchronous pin and strap
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         bi_sync    <= 2'h0;
         strap_sync <= 2'h0;
      end else if (clk_en) begin
         bi_sync    <= {bi_sync[0], bus_init_signal};
         strap_sync <= {strap_sync[0], bus_init_strap};
      end
   end

   // Strap is caught once the synchroniser has flushed after reset, then held
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         strap_wait  <= 2'h0;
         strap_seen  <= 1'b0;
         strap_taken <= 1'b0;
      end else if (clk_en && !strap_taken) begin
         if (strap_wait == 2'h2) begin
            strap_seen  <= strap_sync[1];
            strap_taken <= 1'b1;
         end else begin
            strap_wait <= strap_wait + 2'h1;
         end
      end
   end

   // Rising edge of the synchronised bus-init level
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         bi_prev <= 1'b0;
      end else if (clk_en) begin
         bi_prev <= bi_sync[1];
      end
   end

   assign bi_rise  = bi_sync[1] && !bi_prev;
   assign bi_event = bi_rise && strap_taken && strap_seen && ctrl[mcr_pkg::CTRL_MCE_BIT];

   // Select what gets logged this cycle; bus-init takes priority and goes to bank 0
   always_comb begin
      log_en    = bi_event || err_valid;
      log_bank  = err_bank;
      next_code = encode(err_kind, err_filter, err_level, err_type, err_request,
                         err_part, err_timeout, err_detail);
      if (bi_event) begin
         log_bank  = 2'h0;
         next_code = mcr_pkg::CODE_EXTERNAL;
      end
   end

   // Wishbone decode
   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_req = wb_req && wb_we_i && wb_sel_i[0];

   always_comb begin
      bank_clr_mask = 8'h00;
      if (wr_req && wb_adr_i == mcr_pkg::OFS_BANK_CLR) begin
         bank_clr_mask = wb_dat_i[7:0];
      end
   end

   // Bank status registers: a new event overwrites, and wins over a clear
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         for (int i = 0; i < NB; i++) begin
            bank_error_status_register[i] <= {16'h0000, mcr_pkg::CODE_NONE};
         end
      end else if (clk_en) begin
         for (int i = 0; i < NB; i++) begin
            if (log_en && log_bank == i[1:0]) begin
               bank_error_status_register[i][15:0] <= next_code;
               bank_error_status_register[i][30:16] <= err_model_code[14:0];
               bank_error_status_register[i][mcr_pkg::STAT_VALID_BIT] <= 1'b1;
            end else if (bank_clr_mask[i]) begin
               bank_error_status_register[i] <= {16'h0000, mcr_pkg::CODE_NONE};
            end
         end
      end
   end

   // Control register
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ctrl <= mcr_pkg::CTRL_RESET;
      end else if (clk_en && wr_req && wb_adr_i == mcr_pkg::OFS_CTRL) begin
         ctrl <= {31'h0, wb_dat_i[mcr_pkg::CTRL_MCE_BIT]};
      end
   end

   // Interrupt enable register
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         irq_en <= mcr_pkg::IRQ_RESET;
      end else if (clk_en && wr_req && wb_adr_i == mcr_pkg::OFS_IRQ_EN) begin
         irq_en <= wb_dat_i[7:0];
      end
   end

   // Sticky status: bits 3:0 bank logged, bit 4 bus-init machine check
   always_comb begin
      irq_set = 8'h00;
      if (log_en) begin
         irq_set[log_bank] = 1'b1;
      end
      irq_set[4] = bi_event;
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         irq_stat <= mcr_pkg::IRQ_RESET;
      end else if (clk_en) begin
         if (wr_req && wb_adr_i == mcr_pkg::OFS_IRQ_CLR) begin
            irq_stat <= (irq_stat & ~wb_dat_i[7:0]) | irq_set;
         end else begin
            irq_stat <= irq_stat | irq_set;
         end
      end
   end

   // Outputs from flops
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         irq           <= 1'b0;
         machine_check <= 1'b0;
      end else if (clk_en) begin
         irq           <= |(irq_stat & irq_en);
         machine_check <= bi_event;
      end
   end

   // Wishbone ack and read data, one cycle after the strobe
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else if (clk_en) begin
         wb_ack_o <= wb_req;
         wb_dat_o <= 32'h0000_0000;
         if (wb_req && !wb_we_i) begin
            unique case (wb_adr_i)
               mcr_pkg::OFS_CTRL:     wb_dat_o <= ctrl;
               mcr_pkg::OFS_IRQ_STAT: wb_dat_o <= {24'h0, irq_stat};
               mcr_pkg::OFS_IRQ_EN:   wb_dat_o <= {24'h0, irq_en};
               8'h10:                 wb_dat_o <= bank_error_status_register[0];
               8'h14:                 wb_dat_o <= bank_error_status_register[1];
               8'h18:                 wb_dat_o <= bank_error_status_register[2];
               8'h1c:                 wb_dat_o <= bank_error_status_register[3];
               default:               wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule : mcr_reporter

// [tb/mcr_props.sv]
// Port-level checker for the machine-check error code reporter
`timescale 1ns/1ns
module mcr_props (
   // Clock, reset and enable
   input wire logic        sys_clk,
   input wire logic        reset,
   input wire logic        clk_en,
   // Register bus
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // Bus-init pin and outputs
   input wire logic        bus_init_signal,
   input wire logic        bus_init_strap,
   input wire logic        machine_check,
   input wire logic        irq
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   // A request the slave takes on this edge
   wire take = wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en;

   ack_answer_a: assert property (take |=> wb_ack_o)
      else $error("request not answered in the next cycle");
   ack_pulse_a: assert property (wb_ack_o && clk_en |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without a request");
   unmapped_zero_a: assert property (take && !wb_we_i && wb_adr_i >= 8'h24 |=> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   mc_pulse_a: assert property (machine_check && clk_en |=> !machine_check)
      else $error("machine check longer than one cycle");
   mc_pin_a: assert property (machine_check |-> $past(bus_init_signal, 3))
      else $error("machine check without bus-init pin");
   mc_strap_a: assert property (machine_check |-> bus_init_strap)
      else $error("machine check with observation strapped off");
   reset_quiet_a: assert property (disable iff (1'b0) reset |=> !wb_ack_o && !irq && !machine_check)
      else $error("outputs active after reset");
endmodule : mcr_props
bind mcr_reporter mcr_props u_props (.sys_clk, .reset, .clk_en, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
   .wb_dat_o, .wb_ack_o, .bus_init_signal, .bus_init_strap, .machine_check, .irq);

// [tb/tb.sv]
// Self-checking bench for the machine-check error code reporter
`timescale 1ns/1ns
module tb;
   logic        sys_clk = 0, reset = 1, clk_en = 1, err_valid = 0, err_filter = 0, err_timeout = 0;
   logic        wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, machine_check, irq;
   logic        bus_init_signal = 0, bus_init_strap = 1;
   logic [7:0]  wb_adr_i = 0;
   logic [3:0]  wb_sel_i = 4'hf, err_kind = 0, err_request = 0;
   logic [1:0]  err_bank = 0, err_level = 0, err_type = 0, err_part = 0;
   logic [9:0]  err_detail = 0;
   logic [15:0] err_model_code = 0;
   logic [31:0] wb_dat_i = 0, wb_dat_o, seed = 32'h0c03ddbd, r;
   logic [63:0] q[$], e;
   int          fails = 0, comparisons = 0, cycles = 0, pulses = 0;

   mcr_reporter uut (.sys_clk, .reset, .clk_en, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_dat_o, .wb_ack_o, .err_valid, .err_kind, .err_bank, .err_filter, .err_level, .err_type, .err_request,
      .err_part, .err_timeout, .err_detail, .err_model_code, .bus_init_signal, .bus_init_strap, .machine_check, .irq);

   // Clock
   always #4 sys_clk = ~sys_clk;

   // Compare one result and count it
   task check(input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: expected %h got %h", $time, exp, got);
      end
   endtask : check

   // Final counts and verdict
   task stop_test;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : stop_test

   // Shift-xor generator for event fields
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   // Expected code for the event now on the inputs
   function automatic logic [15:0] code(input logic [3:0] k);
      case (k)
         4'h0: return 16'h0001;
         4'h1: return 16'h0002;
         4'h2: return 16'h0003;
         4'h3: return 16'h0004;
         4'h4: return 16'h0400;
         4'h5: return (err_detail == 10'h0) ? 16'h0401 : {6'h01, err_detail};
         4'h6: return {3'h0, err_filter, 8'h00, 2'h3, err_level};
         4'h7: return {3'h0, err_filter, 7'h00, 1'b1, err_type, err_level};
         4'h8: return {3'h0, err_filter, 3'h0, 1'b1, err_request, err_type, err_level};
         4'h9: return {3'h0, err_filter, 1'b1, err_part, err_timeout, err_request, err_type, err_level};
         default: return 16'h0001;
      endcase
   endfunction : code

   // One classic Wishbone cycle, entered just after a rising edge
   task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      wb_cyc_i <= 1;
      wb_stb_i <= 1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
      wb_cyc_i <= 0;
      wb_stb_i <= 0;
      wb_we_i  <= 0;
      @(posedge sys_clk);
   endtask : bus

   // Read with the expected masked value noted first
   task rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hffffffff);
      q.push_back({m, exp & m});
      bus(a, 1'b0, 32'h0);
   endtask : rd

   // One random event of the given kind
   task ev(input int i);
      r = rnd();
      err_kind       <= 4'(i);
      {err_bank, err_filter, err_level, err_type, err_request, err_part, err_timeout} <= r[13:0];
      err_detail     <= (i < 16) ? 10'h0 : r[24:15];
      err_model_code <= r[31:16];
      err_valid      <= 1;
      @(posedge sys_clk);
      err_valid      <= 0;
      @(posedge sys_clk);
   endtask : ev

   // Clear all banks and interrupt status
   task clr;
      bus(8'h20, 1'b1, 32'hf);
      bus(8'h0c, 1'b1, 32'h1f);
      repeat (2) @(posedge sys_clk);
   endtask : clr

   // Result monitor and watchdog
   always @(posedge sys_clk) begin
      cycles++;
      if (machine_check === 1'b1) pulses++;
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && q.size() > 0) begin
         e = q.pop_front();
         check(e[31:0], wb_dat_o & e[63:32]);
      end
      if (cycles == 4000) begin
         fails++;
         stop_test();
      end
   end

   // Main sequence
   initial begin
      repeat (2) @(posedge sys_clk);
      reset <= 0;
      for (int b = 0; b < 4; b++) rd(8'(16 + 4 * b), 32'h0);
      rd(8'h40, 32'h0);
      $display("test done: reset and unmapped");
      bus(8'h08, 1'b1, 32'hf);
      for (int i = 0; i < 32; i++) begin
         ev(i);
         rd({4'h1, err_bank, 2'h0}, {1'b1, err_model_code[14:0], code(err_kind)});
      end
      bus({4'h1, err_bank, 2'h0}, 1'b1, 32'h0);
      rd({4'h1, err_bank, 2'h0}, {1'b1, err_model_code[14:0], code(err_kind)});
      check(32'h1, {31'h0, irq});
      clr();
      check(32'h0, {31'h0, irq});
      for (int b = 0; b < 4; b++) rd(8'(16 + 4 * b), 32'h0);
      $display("test done: event codes");
      bus(8'h08, 1'b1, 32'h0);
      ev(9);
      repeat (2) @(posedge sys_clk);
      check(32'h0, {31'h0, irq});
      rd(8'h04, 32'h1 << err_bank, 32'hf);
      bus(8'h08, 1'b1, 32'hf);
      repeat (2) @(posedge sys_clk);
      check(32'h1, {31'h0, irq});
      clr();
      $display("test done: interrupt mask");
      bus_init_signal <= 1;
      repeat (10) @(posedge sys_clk);
      bus_init_signal <= 0;
      repeat (4) @(posedge sys_clk);
      check(32'h0, 32'(pulses));
      rd(8'h10, 32'h0);
      bus(8'h00, 1'b1, 32'h1);
      bus_init_signal <= 1;
      repeat (10) @(posedge sys_clk);
      bus_init_signal <= 0;
      repeat (4) @(posedge sys_clk);
      check(32'h1, 32'(pulses));
      rd(8'h10, 32'h80000003, 32'h8000ffff);
      $display("test done: bus-init");
      stop_test();
   end
endmodule : tb
